/* core/fault_persist.sv */
// Persistence filter for one shared fault line
`timescale 1ns/1ps
module fault_persist
  import pg_fault_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic line_low,
  output logic      confirmed_q,
  output logic      trip_q
);

  localparam logic [PCNT_W-1:0] LAST = PCNT_W'(PERSIST_CYCLES - 1);

  logic [PCNT_W-1:0] cnt_q;
  logic [PCNT_W-1:0] cnt_d;
  logic              confirmed_d;
  logic              trip_d;

  // A release before the count ends clears it, so glitches leave no trace
  always_comb begin
    cnt_d       = cnt_q;
    confirmed_d = confirmed_q;
    trip_d      = 1'b0;
    if (!line_low) begin
      cnt_d       = '0;
      confirmed_d = 1'b0;
    end else if (!confirmed_q) begin
      if (cnt_q == LAST) begin
        confirmed_d = 1'b1;
        trip_d      = 1'b1;
      end else begin
        cnt_d = cnt_q + PCNT_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q       <= '0;
      confirmed_q <= 1'b0;
      trip_q      <= 1'b0;
    end else begin
      cnt_q       <= cnt_d;
      confirmed_q <= confirmed_d;
      trip_q      <= trip_d;
    end
  end

endmodule

/* core/power_good_fault.sv */
// Power-good combiner and shared fault line response for eight channels
`timescale 1ns/1ps
// How it works
// - Enabled watchdog alive status gates power good
// - Enabled channel good status ANDed into output
// - Disabled watchdog never affects power good
// - Disabled channel never affects power good
// - Odd high-resolution channels excluded from power good
// - Reserved register bits read back zero
// - Zone0 line registers pick channels 0-3 shutdown
// - Zone1 line registers pick channels 4-7 shutdown
// - Shut down only after 10us persistent assertion
// - Restart channel when line deasserts, via sequencer
// - Response bit zero ignores fault line
// - Fault shutdown drives alert output low
// - Fault shutdown sets channel status bit
// - Fault lines active low, shared
module power_good_fault
  import pg_fault_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  input  wire reg_cmd_t            reg_cmd,
  output logic [15:0]              reg_rd_data_q,
  output logic                     reg_rd_valid_q,
  input  wire logic [CHANNELS-1:0] chan_good_in,
  input  wire logic                wdog_alive_in,
  input  wire logic [CHANNELS-1:0] hires_mode_in,
  input  wire fault_lines_t        fault_line_in,
  output logic                     power_good_q,
  output logic                     alert_output_n_q,
  output logic [CHANNELS-1:0]      chan_off_q,
  output logic [CHANNELS-1:0]      chan_restart_q
);

  logic [GOOD_MASK_W-1:0]             good_mask_q;
  logic [GOOD_MASK_W-1:0]             good_mask_d;
  logic [FAULT_LINES-1:0][RESP_W-1:0] resp_q;
  logic [FAULT_LINES-1:0][RESP_W-1:0] resp_d;
  logic [CHANNELS-1:0]                status_q;
  logic [CHANNELS-1:0]                status_d;
  logic [CHANNELS-1:0]                status_set;
  logic [15:0]                        rd_data_d;
  logic                               rd_valid_d;
  logic [FAULT_LINES-1:0]             sync1_q;
  logic [FAULT_LINES-1:0]             sync2_q;
  logic [FAULT_LINES-1:0]             confirmed;
  logic [FAULT_LINES-1:0]             trip;
  logic [CHANNELS-1:0]                good_use;
  logic                               power_good_d;
  logic                               alert_n_d;
  logic [CHANNELS-1:0]                off_d;
  logic [CHANNELS-1:0]                restart_d;

  // Register file on the command port
  always_comb begin
    good_mask_d = good_mask_q;
    resp_d      = resp_q;
    rd_data_d   = reg_rd_data_q;
    rd_valid_d  = 1'b0;
    if (reg_cmd.wr_en) begin
      case (reg_cmd.sel)
        SEL_GOOD_MASK: good_mask_d = reg_cmd.wr_data[GOOD_MASK_W-1:0];
        SEL_Z0A_RESP:  resp_d[0]   = reg_cmd.wr_data[RESP_W-1:0];
        SEL_Z0B_RESP:  resp_d[1]   = reg_cmd.wr_data[RESP_W-1:0];
        SEL_Z1A_RESP:  resp_d[2]   = reg_cmd.wr_data[RESP_W-1:0];
        SEL_Z1B_RESP:  resp_d[3]   = reg_cmd.wr_data[RESP_W-1:0];
        default:       good_mask_d = good_mask_q;
      endcase
    end
    if (reg_cmd.rd_en) begin
      rd_valid_d = 1'b1;
      // Upper bits padded with zeros
      case (reg_cmd.sel)
        SEL_GOOD_MASK:  rd_data_d = {7'h00, good_mask_q};
        SEL_Z0A_RESP:   rd_data_d = {12'h000, resp_q[0]};
        SEL_Z0B_RESP:   rd_data_d = {12'h000, resp_q[1]};
        SEL_Z1A_RESP:   rd_data_d = {12'h000, resp_q[2]};
        SEL_Z1B_RESP:   rd_data_d = {12'h000, resp_q[3]};
        SEL_MFR_STATUS: rd_data_d = {8'h00, status_q};
        default:        rd_data_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      good_mask_q    <= GOOD_MASK_RESET;
      resp_q         <= {FAULT_LINES{RESP_RESET}};
      reg_rd_data_q  <= 16'h0000;
      reg_rd_valid_q <= 1'b0;
    end else begin
      good_mask_q    <= good_mask_d;
      resp_q         <= resp_d;
      reg_rd_data_q  <= rd_data_d;
      reg_rd_valid_q <= rd_valid_d;
    end
  end

  // Power-good combination; an empty selection reads as good
  always_comb begin
    for (int n = 0; n < CHANNELS; n++) begin
      good_use[n] = good_mask_q[n] && !((n % 2 == 1) && hires_mode_in[n]);
    end
    power_good_d = (&(~good_use | chan_good_in))
                && (!good_mask_q[GOOD_WDOG_BIT] || wdog_alive_in);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      power_good_q <= 1'b0;
    end else begin
      power_good_q <= power_good_d;
    end
  end

  // Lines come from other packages, so two flops before any use
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= ~fault_line_in;
      sync2_q <= sync1_q;
    end
  end

  for (genvar p = 0; p < FAULT_LINES; p++) begin : g_line
    fault_persist u_persist (
      .ref_clk     (ref_clk),
      .reset_n     (reset_n),
      .line_low    (sync2_q[p]),
      .confirmed_q (confirmed[p]),
      .trip_q      (trip[p])
    );
  end

  // Per-channel response; cause bits keep the channel off until its own lines release
  for (genvar n = 0; n < CHANNELS; n++) begin : g_chan
    localparam int unsigned LA = (n / ZONE_CHANNELS) * 2;
    localparam int unsigned LB = LA + 1;
    localparam int unsigned K  = n % ZONE_CHANNELS;
    chan_state_t state_q;
    chan_state_t state_d;
    logic [1:0]  cause_q;
    logic [1:0]  cause_d;
    logic [1:0]  hit;

    always_comb begin
      hit       = {trip[LB] && resp_q[LB][K], trip[LA] && resp_q[LA][K]};
      state_d   = state_q;
      cause_d   = cause_q;
      off_d[n]  = chan_off_q[n];
      restart_d[n] = 1'b0;
      status_set[n] = 1'b0;
      case (state_q)
        CH_RUN: begin
          if (|hit) begin
            state_d       = CH_OFF;
            cause_d       = hit;
            off_d[n]      = 1'b1;
            status_set[n] = 1'b1;
          end
        end
        CH_OFF: begin
          cause_d = (cause_q | hit) & {confirmed[LB], confirmed[LA]};
          if (cause_d == 2'b00) begin
            // Sequencer reapplies turn-on delay and ramp on this pulse
            state_d      = CH_RUN;
            off_d[n]     = 1'b0;
            restart_d[n] = 1'b1;
          end
        end
        default: begin
          state_d  = CH_RUN;
          cause_d  = 2'b00;
          off_d[n] = 1'b0;
        end
      endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        state_q           <= CH_RUN;
        cause_q           <= 2'b00;
        chan_off_q[n]     <= 1'b0;
        chan_restart_q[n] <= 1'b0;
      end else begin
        state_q           <= state_d;
        cause_q           <= cause_d;
        chan_off_q[n]     <= off_d[n];
        chan_restart_q[n] <= restart_d[n];
      end
    end
  end

  // Sticky status; write one to clear, a new event wins over the clear
  always_comb begin
    status_d = status_q;
    if (reg_cmd.wr_en && reg_cmd.sel == SEL_MFR_STATUS) begin
      status_d = status_q & ~reg_cmd.wr_data[CHANNELS-1:0];
    end
    status_d  = status_d | status_set;
    alert_n_d = ~|status_d;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q         <= '0;
      alert_output_n_q <= 1'b1;
    end else begin
      status_q         <= status_d;
      alert_output_n_q <= alert_n_d;
    end
  end

  // Checks
  logic [2:0] rd_sel_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_sel_q <= 3'h0;
    end else begin
      rd_sel_q <= reg_cmd.sel;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_wdog_gates_good: assert property (
    good_mask_q[GOOD_WDOG_BIT] && !wdog_alive_in |=> !power_good_q)
    else $error("watchdog expiry did not drop power good");
  a_chan_gates_good: assert property (
    |(good_use & ~chan_good_in) |=> !power_good_q)
    else $error("enabled bad channel did not drop power good");
  a_wdog_ignored: assert property (
    !good_mask_q[GOOD_WDOG_BIT] && (&(~good_use | chan_good_in)) |=> power_good_q)
    else $error("disabled watchdog affected power good");
  a_chan_excluded: assert property (
    good_mask_q[7:0] == 8'h00 && !good_mask_q[GOOD_WDOG_BIT] |=> power_good_q)
    else $error("disabled channels affected power good");
  a_hires_excluded: assert property (
    hires_mode_in[1] && !chan_good_in[1] && (&(~good_use | chan_good_in))
      && !good_mask_q[GOOD_WDOG_BIT] |=> power_good_q)
    else $error("high resolution odd channel affected power good");
  a_reserved_zero: assert property (
    reg_rd_valid_q && rd_sel_q != SEL_GOOD_MASK |-> reg_rd_data_q[15:8] == 8'h00
      && (rd_sel_q == SEL_MFR_STATUS || reg_rd_data_q[7:4] == 4'h0))
    else $error("reserved bits read nonzero");
  a_zone0_shutdown: assert property (
    trip[1] && resp_q[1][3] && !chan_off_q[3] |=> chan_off_q[3])
    else $error("zone0 line b did not shut channel 3");
  a_zone1_shutdown: assert property (
    trip[2] && resp_q[2][0] && !chan_off_q[4] && !chan_off_q[0] && !trip[0] && !trip[1]
      |=> chan_off_q[4] && !chan_off_q[0])
    else $error("zone1 line a response wrong");
  a_persist_time: assert property (
    $rose(chan_off_q[0]) |-> $past(sync2_q[0], 2) && $past(sync2_q[0], 200)
      || $past(sync2_q[1], 2) && $past(sync2_q[1], 200))
    else $error("shutdown without persistent assertion");
  a_restart_release: assert property (
    $fell(chan_off_q[0]) |-> chan_restart_q[0]
      && !($past(confirmed[0]) && $past(resp_q[0][0]))
      && !($past(confirmed[1]) && $past(resp_q[1][0])) ##1 !chan_restart_q[0])
    else $error("restart pulse wrong");
  a_ignore_line: assert property (
    resp_q[0][0] == 1'b0 && resp_q[1][0] == 1'b0 && !chan_off_q[0] |=> !chan_off_q[0])
    else $error("ignored line shut channel 0");
  a_alert_low: assert property (
    $rose(chan_off_q[5]) |-> !alert_output_n_q)
    else $error("alert not asserted on shutdown");
  a_status_set: assert property (
    $rose(chan_off_q[6]) |-> status_q[6])
    else $error("status bit not set on shutdown");
  a_short_glitch: assert property (
    !sync2_q[0] && !sync2_q[1] && !confirmed[0] && !confirmed[1] && !chan_off_q[2]
      |=> !chan_off_q[2])
    else $error("shutdown without line asserted");

  c_shutdown: cover property ($rose(chan_off_q[0]));
  c_restart:  cover property (chan_restart_q[4]);
  c_glitch:   cover property (sync2_q[0] [*8] ##1 !sync2_q[0]);
  c_good:     cover property ($rose(power_good_q) && good_mask_q[GOOD_WDOG_BIT]);

endmodule

/* inc/pg_fault_pkg.sv */
// Shared constants, register selects and carrier types for the power-good and fault block
package pg_fault_pkg;

  localparam int unsigned CHANNELS      = 8;
  localparam int unsigned ZONE_CHANNELS = 4;
  localparam int unsigned FAULT_LINES   = 4;

  // Clock rate and persistence time
  localparam int unsigned CLK_KHZ        = 40000;
  localparam int unsigned PERSIST_NS     = 10000;
  // Least time, so round up
  localparam int unsigned PERSIST_CYCLES = (PERSIST_NS * CLK_KHZ + 999999) / 1000000;
  localparam int unsigned PCNT_W         = 9;

  // Register selects on the command port
  localparam logic [2:0] SEL_GOOD_MASK  = 3'h0;
  localparam logic [2:0] SEL_Z0A_RESP   = 3'h1;
  localparam logic [2:0] SEL_Z0B_RESP   = 3'h2;
  localparam logic [2:0] SEL_Z1A_RESP   = 3'h3;
  localparam logic [2:0] SEL_Z1B_RESP   = 3'h4;
  localparam logic [2:0] SEL_MFR_STATUS = 3'h5;

  // Field layout
  localparam int unsigned GOOD_WDOG_BIT = 8;
  localparam int unsigned GOOD_MASK_W   = 9;
  localparam int unsigned RESP_W        = 4;

  // Reset values
  localparam logic [GOOD_MASK_W-1:0] GOOD_MASK_RESET = 9'h000;
  localparam logic [RESP_W-1:0]      RESP_RESET      = 4'h0;

  // Fault lines, index 0 zone0 a, 1 zone0 b, 2 zone1 a, 3 zone1 b
  typedef struct packed {
    logic zone1_fault_line_b;
    logic zone1_fault_line_a;
    logic zone0_fault_line_b;
    logic zone0_fault_line_a;
  } fault_lines_t;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [2:0] sel;
    logic [15:0] wr_data;
  } reg_cmd_t;

  typedef enum logic {
    CH_RUN,
    CH_OFF
  } chan_state_t;

endpackage

/* test/fault_line_peers.sv */
// Other managers sharing the four open-drain fault lines
`timescale 1ns/1ps
module fault_line_peers
  import pg_fault_pkg::*;
(
  input  wire logic [FAULT_LINES-1:0] pull_low,
  output fault_lines_t                lines
);
  // A released line goes to its pull-up, so a stale low level is never seen
  assign lines = fault_lines_t'(~pull_low);
endmodule

/* test/power_good_fault_test.sv */
// Self-checking bench for the power-good combiner and fault line response
`timescale 1ns/1ps
module power_good_fault_test
  import pg_fault_pkg::*;
;
  logic         ref_clk = 1'b0;
  logic         reset_n = 1'b0;
  reg_cmd_t     cmd = '0;
  logic [15:0]  rd_data;
  logic         rd_valid;
  logic [7:0]   good = 8'hFF;
  logic         wdog = 1'b1;
  logic [7:0]   hires = 8'h00;
  logic [3:0]   pull = 4'h0;
  fault_lines_t lines;
  logic         pg;
  logic         alert_n;
  logic [7:0]   off;
  logic [7:0]   restart;
  logic [7:0]   restart_seen = 8'h00;
  logic [15:0]  rnd = 16'h784F;
  int           errors = 0;
  int           samples_checked = 0;
  int           cycles = 0;

  always #12.5 ref_clk = ~ref_clk;

  fault_line_peers peers (.pull_low(pull), .lines(lines));

  power_good_fault uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_cmd(cmd), .reg_rd_data_q(rd_data),
    .reg_rd_valid_q(rd_valid), .chan_good_in(good), .wdog_alive_in(wdog),
    .hires_mode_in(hires), .fault_line_in(lines), .power_good_q(pg),
    .alert_output_n_q(alert_n), .chan_off_q(off), .chan_restart_q(restart)
  );

  // Restart is a one-cycle pulse, so collect it rather than poll it
  always @(posedge ref_clk) begin
    restart_seen <= restart_seen ^ restart;
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic pg_exp(input logic [8:0] m, input logic [7:0] g,
                                  input logic w, input logic [7:0] h);
    logic r;
    r = !m[8] || w;
    for (int n = 0; n < 8; n++) begin
      if (m[n] && !(n % 2 == 1 && h[n]) && !g[n]) r = 1'b0;
    end
    return r;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] sel, input logic [15:0] d);
    cmd.wr_en = 1'b1;
    cmd.sel = sel;
    cmd.wr_data = d;
    @(negedge ref_clk);
    cmd.wr_en = 1'b0;
    // Idle edge so the next call never re-raises the strobe at once
    @(negedge ref_clk);
  endtask

  task automatic rd(input logic [2:0] sel, input logic [15:0] exp);
    cmd.rd_en = 1'b1;
    cmd.sel = sel;
    @(negedge ref_clk);
    check({15'h0, rd_valid}, 16'h0001);
    check(rd_data, exp);
    cmd.rd_en = 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic end_sim;
    $display("Checked %0d, errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic fault_case(input int l, input logic [3:0] resp);
    logic [7:0] exp;
    logic [7:0] base;
    exp = {4'h0, resp} << (4 * (l / 2));
    for (int s = 1; s < 5; s++) wr(3'(s), (s == l + 1) ? {12'h0, resp} : 16'h0000);
    wr(SEL_MFR_STATUS, 16'h00FF);
    pull[l] = 1'b1;
    repeat (300) @(negedge ref_clk);
    pull[l] = 1'b0;
    repeat (8) @(negedge ref_clk);
    check({8'h0, off}, 16'h0000);
    check({15'h0, alert_n}, 16'h0001);
    pull[l] = 1'b1;
    repeat (420) @(negedge ref_clk);
    check({8'h0, off}, {8'h0, exp});
    check({15'h0, alert_n}, {15'h0, exp == 8'h00});
    rd(SEL_MFR_STATUS, {8'h0, exp});
    base = restart_seen;
    pull[l] = 1'b0;
    repeat (8) @(negedge ref_clk);
    check({8'h0, off}, 16'h0000);
    check({8'h0, restart_seen ^ base}, {8'h0, exp});
    wr(SEL_MFR_STATUS, 16'h00FF);
    repeat (2) @(negedge ref_clk);
    check({15'h0, alert_n}, 16'h0001);
  endtask

  initial begin
    logic [8:0] m;
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
    for (int s = 0; s < 8; s++) rd(3'(s), 16'h0000);
    wr(SEL_GOOD_MASK, 16'hFFFF);
    rd(SEL_GOOD_MASK, 16'h01FF);
    for (int s = 1; s < 5; s++) begin
      wr(3'(s), 16'hFFFF);
      rd(3'(s), 16'h000F);
    end
    $display("Register test done");
    // Odd channels in high-res mode drop out even when enabled
    wr(SEL_GOOD_MASK, 16'h01AA);
    {good, wdog, hires} = {8'h55, 1'b1, 8'hFF};
    @(negedge ref_clk);
    check({15'h0, pg}, 16'h0001);
    for (int i = 0; i < 60; i++) begin
      rnd = lfsr(rnd);
      m = rnd[8:0];
      wr(SEL_GOOD_MASK, {7'h0, m});
      rnd = lfsr(rnd);
      good = rnd[7:0] | rnd[15:8];
      wdog = rnd[3] | rnd[9];
      rnd = lfsr(rnd);
      hires = rnd[7:0];
      @(negedge ref_clk);
      check({15'h0, pg}, {15'h0, pg_exp(m, good, wdog, hires)});
    end
    $display("Power good test done");
    good = 8'hFF;
    for (int l = 0; l < 4; l++) begin
      rnd = lfsr(rnd);
      fault_case(l, rnd[3:0] | (l[0] ? 4'h9 : 4'h7));
    end
    $display("Fault line test done");
    end_sim();
  end
endmodule
